//--- hw/lsm_pkg.sv
package lsm_pkg;
  // register indices, address width and register width
  localparam logic [7:0] LSM_IDX_MODE = 8'h17;
  localparam logic [7:0] LSM_IDX_BIAS = 8'h18;
  localparam logic [7:0] LSM_IDX_CAL = 8'h19;
  localparam logic [7:0] LSM_IDX_SEED = 8'h1A;
  localparam logic [7:0] LSM_IDX_STATUS = 8'h1B;
  localparam logic [7:0] LSM_IDX_PHASE = 8'h1C;
  localparam int LSM_AW = 10;
  localparam int LSM_RW = 24;
  // reset values and the calibration word that the status compares against
  localparam logic [23:0] LSM_RST_MODE = 24'h0001AB;
  localparam logic [23:0] LSM_RST_BIAS = 24'h0054C1;
  localparam logic [23:0] LSM_RST_CAL = 24'h000AAA;
  localparam logic [23:0] LSM_RST_SEED = 24'hB29D0B;
  localparam logic [23:0] LSM_CAL_REQUIRED = 24'h000AB2;
  // writable bit masks
  localparam logic [23:0] LSM_MASK_MODE = 24'h000BFF;
  localparam logic [23:0] LSM_MASK_ALL = 24'hFFFFFF;
  // mode field positions
  localparam int LSM_M_SUBSYS = 0;
  localparam int LSM_M_VCO = 1;
  localparam int LSM_M_EXTBUF = 2;
  localparam int LSM_M_PLLBUF = 3;
  localparam int LSM_M_OUT1 = 4;
  localparam int LSM_M_OUT2 = 5;
  localparam int LSM_M_EXTIN = 6;
  localparam int LSM_M_MUTE = 7;
  localparam int LSM_M_SE1 = 8;
  localparam int LSM_M_SE2 = 9;
  localparam int LSM_M_PUMP = 11;
  // bias field positions
  localparam int LSM_B_BIAS0 = 19;
  localparam int LSM_B_BIAS1 = 20;
  // status field positions
  localparam int LSM_S_LOCK = 0;
  localparam int LSM_S_CHIPEN = 1;
  localparam int LSM_S_SUBSYS = 2;
  localparam int LSM_S_MUTED = 3;
  localparam int LSM_S_CALOK = 4;
  localparam int LSM_S_PHVALID = 5;
  // synchroniser depth
  localparam int LSM_SYNC_STAGES = 3;
endpackage : lsm_pkg

//--- hw/lsm_regs.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module lsm_regs
  import lsm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsm_pkg::LSM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside
  input wire logic chip_enable_pin,
  input wire logic pll_lock_pin,
  // synthesizer core status, same clock
  input wire logic exact_freq_mode,
  input wire logic auto_seed_enable,
  input wire logic freq_change,
  // analog enables
  output logic vco_subsys_enable,
  output logic vco_core_enable,
  output logic ext_vco_buf_enable,
  output logic pll_buf_enable,
  output logic ext_input_enable,
  output logic first_oscillator_output_enable,
  output logic first_out_true_pin_enable,
  output logic first_out_complement_pin_enable,
  output logic second_oscillator_output_enable,
  output logic second_out_true_pin_enable,
  output logic second_out_complement_pin_enable,
  output logic first_pump_output_enable,
  output logic second_pump_output_enable,
  output logic [1:0] ext_input_bias,
  output logic [23:0] reserved_bias,
  output logic [23:0] calibration_word,
  // modulator seed
  output logic [23:0] seed_phase_word,
  output logic seed_load
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [LSM_SYNC_STAGES-1:0] chip_sync_q, chip_sync_d;
  logic [LSM_SYNC_STAGES-1:0] lock_sync_q, lock_sync_d;
  logic chip_en_q, chip_en_d;
  logic lock_q, lock_d;

  always_comb
  begin
    chip_sync_d = {chip_sync_q[LSM_SYNC_STAGES-2:0], chip_enable_pin};
    lock_sync_d = {lock_sync_q[LSM_SYNC_STAGES-2:0], pll_lock_pin};
    // change counts once stages two and three agree
    chip_en_d = chip_en_q;
    if (chip_sync_q[1] == chip_sync_q[2])
    begin
      chip_en_d = chip_sync_q[2];
    end
    lock_d = lock_q;
    if (lock_sync_q[1] == lock_sync_q[2])
    begin
      lock_d = lock_sync_q[2];
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      chip_sync_q <= '0;
      lock_sync_q <= '0;
      chip_en_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      chip_sync_q <= chip_sync_d;
      lock_sync_q <= lock_sync_d;
      chip_en_q <= chip_en_d;
      lock_q <= lock_d;
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic [7:0] idx;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic [23:0] wmask;

  assign idx = paddr[LSM_AW-1:2];
  assign pready = 1'b1;

  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) &&
      ((idx == LSM_IDX_MODE) || (idx == LSM_IDX_BIAS) || (idx == LSM_IDX_CAL) ||
       (idx == LSM_IDX_SEED) || (idx == LSM_IDX_STATUS) || (idx == LSM_IDX_PHASE));
  end

  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lane
      assign wmask[g*8 +: 8] = {8{pstrb[g]}};
    end
  endgenerate

  // ****************************************
  // configuration registers
  // ****************************************
  logic [23:0] mode_q, mode_d;
  logic [23:0] bias_q, bias_d;
  logic [23:0] cal_q, cal_d;
  logic [23:0] seed_q, seed_d;
  logic seed_wr;
  function automatic logic [23:0] lsm_merge(input logic [23:0] old, input logic [23:0] wd,
                                            input logic [23:0] m);
    lsm_merge = (old & ~m) | (wd & m);
  endfunction : lsm_merge
  always_comb
  begin
    mode_d = mode_q;
    bias_d = bias_q;
    cal_d = cal_q;
    seed_d = seed_q;
    seed_wr = 1'b0;
    if (wr_en)
    begin
      case (idx)
        LSM_IDX_MODE: mode_d = lsm_merge(mode_q, pwdata[23:0], wmask & LSM_MASK_MODE);
        LSM_IDX_BIAS: bias_d = lsm_merge(bias_q, pwdata[23:0], wmask);
        LSM_IDX_CAL: cal_d = lsm_merge(cal_q, pwdata[23:0], wmask);
        LSM_IDX_SEED:
        begin
          seed_d = lsm_merge(seed_q, pwdata[23:0], wmask);
          seed_wr = 1'b1;
        end
        default: seed_wr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= LSM_RST_MODE;
      bias_q <= LSM_RST_BIAS;
      cal_q <= LSM_RST_CAL;
      seed_q <= LSM_RST_SEED;
    end
    else
    begin
      mode_q <= mode_d;
      bias_q <= bias_d;
      cal_q <= cal_d;
      seed_q <= seed_d;
    end
  end

  // ****************************************
  // enables and pin drive
  // ****************************************
  logic subsys_on;
  logic muted;
  logic out1_on;
  logic out2_on;
  always_comb
  begin
    subsys_on = mode_q[LSM_M_SUBSYS] && chip_en_q;
    muted = mode_q[LSM_M_MUTE] && !lock_q;
    out1_on = subsys_on && mode_q[LSM_M_OUT1] && !muted;
    out2_on = subsys_on && mode_q[LSM_M_OUT2] && !muted;
  end
  logic [12:0] en_q, en_d;
  always_comb
  begin
    en_d[0] = subsys_on;
    en_d[1] = subsys_on && mode_q[LSM_M_VCO];
    en_d[2] = subsys_on && mode_q[LSM_M_EXTBUF];
    en_d[3] = subsys_on && mode_q[LSM_M_PLLBUF];
    en_d[4] = subsys_on && mode_q[LSM_M_EXTIN];
    en_d[5] = out1_on;
    en_d[6] = out1_on && !mode_q[LSM_M_SE1];
    en_d[7] = out1_on;
    en_d[8] = out2_on;
    en_d[9] = out2_on && !mode_q[LSM_M_SE2];
    en_d[10] = out2_on;
    en_d[11] = subsys_on && !mode_q[LSM_M_PUMP];
    en_d[12] = subsys_on && mode_q[LSM_M_PUMP];
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      en_q <= '0;
    end
    else
    begin
      en_q <= en_d;
    end
  end
  assign vco_subsys_enable = en_q[0];
  assign vco_core_enable = en_q[1];
  assign ext_vco_buf_enable = en_q[2];
  assign pll_buf_enable = en_q[3];
  assign ext_input_enable = en_q[4];
  assign first_oscillator_output_enable = en_q[5];
  assign first_out_true_pin_enable = en_q[6];
  assign first_out_complement_pin_enable = en_q[7];
  assign second_oscillator_output_enable = en_q[8];
  assign second_out_true_pin_enable = en_q[9];
  assign second_out_complement_pin_enable = en_q[10];
  assign first_pump_output_enable = en_q[11];
  assign second_pump_output_enable = en_q[12];
  assign ext_input_bias = {bias_q[LSM_B_BIAS1], bias_q[LSM_B_BIAS0]};
  assign reserved_bias = bias_q;
  assign calibration_word = cal_q;

  // ****************************************
  // seed application
  // ****************************************
  logic [23:0] phase_q, phase_d;
  logic load_q, load_d;
  logic valid_q, valid_d;
  logic exact_q, exact_d;
  always_comb
  begin
    exact_d = exact_freq_mode;
    load_d = 1'b0;
    if (exact_freq_mode)
    begin
      if (auto_seed_enable)
      begin
        load_d = seed_wr || !exact_q;
      end
      else
      begin
        load_d = freq_change || !exact_q;
      end
    end
    phase_d = phase_q;
    valid_d = valid_q && exact_freq_mode;
    if (load_d)
    begin
      phase_d = seed_d;
      valid_d = 1'b1;
    end
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      phase_q <= LSM_RST_SEED;
      load_q <= 1'b0;
      valid_q <= 1'b0;
      exact_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      load_q <= load_d;
      valid_q <= valid_d;
      exact_q <= exact_d;
    end
  end
  assign seed_phase_word = phase_q;
  assign seed_load = load_q;

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rdata_q, rdata_d;
  logic [23:0] status;
  always_comb
  begin
    status = '0;
    status[LSM_S_LOCK] = lock_q;
    status[LSM_S_CHIPEN] = chip_en_q;
    status[LSM_S_SUBSYS] = subsys_on;
    status[LSM_S_MUTED] = muted;
    status[LSM_S_CALOK] = (cal_q == LSM_CAL_REQUIRED);
    status[LSM_S_PHVALID] = valid_q;
    rdata_d = rdata_q;
    if (rd_setup)
    begin
      case (idx)
        LSM_IDX_MODE: rdata_d = {8'h00, mode_q};
        LSM_IDX_BIAS: rdata_d = {8'h00, bias_q};
        LSM_IDX_CAL: rdata_d = {8'h00, cal_q};
        LSM_IDX_SEED: rdata_d = {8'h00, seed_q};
        LSM_IDX_STATUS: rdata_d = {8'h00, status};
        LSM_IDX_PHASE: rdata_d = {8'h00, phase_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end
  assign prdata = rdata_q;
endmodule : lsm_regs

//--- verif/lsm_regs_props.sv
`timescale 1ns/1ps
module lsm_regs_props (
  // clock, reset, bus
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // pins and core status
  input wire logic chip_enable_pin,
  input wire logic exact_freq_mode,
  input wire logic auto_seed_enable,
  input wire logic freq_change,
  // enables and seed
  input wire logic vco_subsys_enable,
  input wire logic first_out_true_pin_enable,
  input wire logic first_out_complement_pin_enable,
  input wire logic second_out_true_pin_enable,
  input wire logic second_out_complement_pin_enable,
  input wire logic first_pump_output_enable,
  input wire logic second_pump_output_enable,
  input wire logic [1:0] ext_input_bias,
  input wire logic [23:0] seed_phase_word,
  input wire logic seed_load
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_PUMP_ONE: assert property (!(first_pump_output_enable && second_pump_output_enable))
    else $error("both pump outputs on");
  AST_CHIP_OFF: assert property (!chip_enable_pin [*8] |-> !vco_subsys_enable)
    else $error("subsystem on without chip enable");
  AST_SE1: assert property (psel && penable && pwrite && paddr == 10'h05C && pstrb[1] && pwdata[8]
    |-> ##2 !first_out_true_pin_enable) else $error("first true pin on in single-ended mode");
  AST_SE2: assert property (psel && penable && pwrite && paddr == 10'h05C && pstrb[1] && pwdata[9]
    |-> ##2 !second_out_true_pin_enable) else $error("second true pin on in single-ended mode");
  AST_BIAS_WR: assert property (psel && penable && pwrite && paddr == 10'h060 && pstrb[2]
    |=> ext_input_bias == $past(pwdata[20:19])) else $error("bias bits not stored");
  AST_LOAD_EXACT: assert property (seed_load |-> $past(exact_freq_mode))
    else $error("seed load outside exact mode");
  AST_FC_LOAD: assert property (exact_freq_mode && !auto_seed_enable && freq_change |=> seed_load)
    else $error("no reload on frequency change");
  AST_WORD_LOAD: assert property ($changed(seed_phase_word) |-> seed_load)
    else $error("phase word changed without load");
  AST_SEED_WR: assert property (exact_freq_mode && auto_seed_enable && psel && penable && pwrite
    && paddr == 10'h068 && pstrb[2:0] == 3'h7 |=> seed_phase_word == $past(pwdata[23:0]))
    else $error("written seed not applied");
endmodule : lsm_regs_props

bind lsm_regs lsm_regs_props i_lsm_regs_props (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .chip_enable_pin, .exact_freq_mode, .auto_seed_enable, .freq_change, .vco_subsys_enable,
  .first_out_true_pin_enable, .first_out_complement_pin_enable, .second_out_true_pin_enable,
  .second_out_complement_pin_enable, .first_pump_output_enable, .second_pump_output_enable,
  .ext_input_bias, .seed_phase_word, .seed_load);

//--- verif/lsm_regs_tb.sv
`timescale 1ns/1ps
module lsm_regs_tb;
  import lsm_pkg::*;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, seed_load;
  logic chip_enable_pin = 0, pll_lock_pin = 0, exact_freq_mode = 0, auto_seed_enable = 0, freq_change = 0;
  logic [9:0] paddr = 0;
  logic [3:0] pstrb = 0;
  logic [31:0] pwdata = 0, prdata, rd, s, t, rs = 32'hF8F2;
  logic vco_subsys_enable, vco_core_enable, ext_vco_buf_enable, pll_buf_enable, ext_input_enable;
  logic first_oscillator_output_enable, first_out_true_pin_enable, first_out_complement_pin_enable;
  logic second_oscillator_output_enable, second_out_true_pin_enable, second_out_complement_pin_enable;
  logic first_pump_output_enable, second_pump_output_enable;
  logic [1:0] ext_input_bias;
  logic [23:0] reserved_bias, calibration_word, seed_phase_word;
  logic [12:0] en;
  logic [9:0] adr [4] = '{10'h05C, 10'h060, 10'h064, 10'h068};
  logic [23:0] rv [4] = '{LSM_RST_MODE, LSM_RST_BIAS, LSM_RST_CAL, LSM_RST_SEED};
  int fails = 0, cmp_count = 0, cyc = 0;
  always #5 clock = ~clock;
  assign en = {vco_subsys_enable, vco_core_enable, ext_vco_buf_enable, pll_buf_enable, ext_input_enable,
    first_oscillator_output_enable, first_out_true_pin_enable, first_out_complement_pin_enable,
    second_oscillator_output_enable, second_out_true_pin_enable, second_out_complement_pin_enable,
    first_pump_output_enable, second_pump_output_enable};
  lsm_regs i_lsm_regs (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .chip_enable_pin, .pll_lock_pin, .exact_freq_mode, .auto_seed_enable, .freq_change,
    .vco_subsys_enable, .vco_core_enable, .ext_vco_buf_enable, .pll_buf_enable, .ext_input_enable,
    .first_oscillator_output_enable, .first_out_true_pin_enable, .first_out_complement_pin_enable,
    .second_oscillator_output_enable, .second_out_true_pin_enable, .second_out_complement_pin_enable,
    .first_pump_output_enable, .second_pump_output_enable, .ext_input_bias, .reserved_bias,
    .calibration_word, .seed_phase_word, .seed_load);
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [12:0] exp_en(logic [31:0] m, logic c, logic l);
    logic u, a, b;
    u = m[0] & c;
    a = u & m[4] & !(m[7] & !l);
    b = u & m[5] & !(m[7] & !l);
    return {u, u & m[1], u & m[2], u & m[3], u & m[6], a, a & !m[8], a, b, b & !m[9], b, u & !m[11], u & m[11]};
  endfunction : exp_en
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1;
    do
    begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic mode_case(input logic [31:0] m, input logic c, input logic l);
    chip_enable_pin <= c;
    pll_lock_pin <= l;
    apb(1, 10'h05C, m);
    repeat (8) @(posedge clock);
    chk("mode enables", {19'h0, en}, {19'h0, exp_en(m, c, l)});
  endtask : mode_case
  task automatic pulse();
    @(posedge clock);
    freq_change <= 1;
    @(posedge clock);
    freq_change <= 0;
    #1;
    chk("seed load", {31'h0, seed_load}, 1);
  endtask : pulse
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 0;
    for (int i = 0; i < 4; i++)
    begin
      apb(0, adr[i], 0);
      chk("reset value", rd, {8'h00, rv[i]});
    end
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      s = rnd();
      apb(1, adr[i % 4], s);
      apb(0, adr[i % 4], 0);
      chk("readback", rd, {8'h00, s[23:0] & (i % 4 == 0 ? LSM_MASK_MODE : LSM_MASK_ALL)});
      if (i % 4 == 1)
        chk("bias bits", {30'h0, ext_input_bias}, {30'h0, s[20:19]});
      if (i % 4 == 1)
        chk("bias word", {8'h00, reserved_bias}, {8'h00, s[23:0]});
      if (i % 4 == 2)
        chk("cal word", {8'h00, calibration_word}, {8'h00, s[23:0]});
    end
    apb(0, 10'h3F0, 0);
    chk("unmapped error", {31'h0, er}, 1);
    chk("unmapped data", rd, 0);
    apb(1, 10'h064, {8'h00, LSM_CAL_REQUIRED});
    apb(0, 10'h06C, 0);
    chk("cal status", {31'h0, rd[LSM_S_CALOK]}, 1);
    chk("cal required", {8'h00, calibration_word}, {8'h00, LSM_CAL_REQUIRED});
    $display("test registers done");
    mode_case(32'h0001AB, 1, 1);
    mode_case(32'h0008BF, 1, 0);
    mode_case(32'h0008BF, 1, 1);
    mode_case(32'h000BFF, 0, 1);
    for (int i = 0; i < 12; i++)
    begin
      t = rnd();
      mode_case(rnd() & 32'h00000BFF, t[1] | t[2], t[0]);
    end
    $display("test modes done");
    s = rnd() & 32'h00FFFFFF;
    apb(1, 10'h068, s);
    exact_freq_mode <= 1;
    repeat (3) @(posedge clock);
    t = rnd() & 32'h00FFFFFF;
    apb(1, 10'h068, t);
    #1;
    chk("no load on write", {8'h00, seed_phase_word}, s);
    pulse();
    chk("reloaded seed", {8'h00, seed_phase_word}, t);
    apb(0, 10'h06C, 0);
    chk("phase valid", {31'h0, rd[LSM_S_PHVALID]}, 1);
    auto_seed_enable <= 1;
    s = rnd() & 32'h00FFFFFF;
    apb(1, 10'h068, s);
    #1;
    chk("auto seed", {8'h00, seed_phase_word}, s);
    exact_freq_mode <= 0;
    apb(1, 10'h068, rnd());
    #1;
    chk("exact off", {8'h00, seed_phase_word}, s);
    apb(0, 10'h070, 0);
    chk("phase readback", rd, s);
    apb(0, 10'h06C, 0);
    chk("phase invalid", {31'h0, rd[LSM_S_PHVALID]}, 0);
    $display("test seed done");
    tally_and_finish();
  end
endmodule : lsm_regs_tb
